// ===== dv/pfrc_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checks
// ****
module pfrc_core_properties
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Inputs seen
	input wire logic i_ser_latch,
	input wire logic i_powered,
	input wire logic i_rf_cmp,
	input wire logic i_if_cmp,
	// Outputs seen
	input wire logic o_fl_oe,
	input wire logic o_rf_ld_cmp,
	input wire logic o_if_ld_cmp,
	input wire logic o_rf_sample,
	input wire pfrc_pkg::pfrc_ctl_t o_ctl,
	input wire logic o_pump_test
);
	import pfrc_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Power-up steps
	sequence s_up; !i_powered ##1 i_powered; endsequence
	sequence s_clr; ##[1:4] (o_ctl.rf_cnt_reset && o_ctl.if_cnt_reset); endsequence
	property p_up; s_up |-> s_clr; endproperty
	a_up: assert property (p_up)
		else $error("no counter reset after power-up");
	property p_ifld; o_if_ld_cmp == i_if_cmp; endproperty
	a_ifld: assert property (p_ifld)
		else $error("IF lock strobe altered");
	property p_rfld; o_rf_ld_cmp |-> i_rf_cmp || $past(i_rf_cmp); endproperty
	a_rfld: assert property (p_rfld)
		else $error("RF lock strobe without compare");
	property p_smp; o_rf_sample |-> $past(i_rf_cmp); endproperty
	a_smp: assert property (p_smp)
		else $error("sample without compare");
	property p_div; o_ctl.slip_div inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h10}; endproperty
	a_div: assert property (p_div)
		else $error("bad slip divide");
	property p_fast; o_ctl.fast_active |-> o_fl_oe; endproperty
	a_fast: assert property (p_fast)
		else $error("fastlock with pin floating");
	property p_rfr; o_ctl.rf_cnt_reset |-> o_ctl.rf_pump_hiz; endproperty
	a_rfr: assert property (p_rfr)
		else $error("RF reset without pump float");
	property p_ifr; o_ctl.if_cnt_reset |-> o_ctl.if_pump_hiz; endproperty
	a_ifr: assert property (p_ifr)
		else $error("IF reset without pump float");
	// Latch held high six cycles by the host
	property p_tst; $changed(o_pump_test) |-> $past(i_ser_latch, 3); endproperty
	a_tst: assert property (p_tst)
		else $error("test bit moved without latch");
endmodule : pfrc_core_properties
bind pfrc_core pfrc_core_properties u_props (.i_mclk, .i_rst, .i_ser_latch, .i_powered,
	.i_rf_cmp, .i_if_cmp, .o_fl_oe, .o_rf_ld_cmp, .o_if_ld_cmp, .o_rf_sample, .o_ctl,
	.o_pump_test);
`default_nettype wire

// ===== dv/pfrc_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Host serial writer
// ****
module pfrc_host
(
	// Clock
	input wire logic i_mclk,
	// Serial pins
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_ser_latch
);
	// Quiet pins
	initial
	begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_ser_latch = 1'b0;
	end
	// Four cycles per level, so the synchroniser never misses an edge
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			@(posedge i_mclk) #1;
			o_ser_clk = 1'b0;
			o_ser_data = w[i];
			repeat (4) @(posedge i_mclk);
			#1 o_ser_clk = 1'b1;
			repeat (3) @(posedge i_mclk);
		end
		@(posedge i_mclk) #1;
		o_ser_clk = 1'b0;
		o_ser_data = ~w[0]; // Idle data not left at last value
		o_ser_latch = 1'b1;
		repeat (6) @(posedge i_mclk);
		#1 o_ser_latch = 1'b0;
		repeat (4) @(posedge i_mclk);
	endtask : send
endmodule : pfrc_host
`default_nettype wire

// ===== dv/pll_fastlock_reset_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module pll_fastlock_reset_control_tb;
	import pfrc_pkg::*;
	logic mclk, rst, sclk, sdata, latch, powered, rfc, ifc;
	logic fl_out, fl_oe, rf_ld, if_ld, smp, ptest;
	pfrc_ctl_t ctl;
	int fail_count, n_compared, n_smp, n_ld, n_if;
	logic [2:0] pin_exp [4] = '{3'b000, 3'b110, 3'b010, 3'b011};
	pfrc_host u_host (.i_mclk(mclk), .o_ser_clk(sclk), .o_ser_data(sdata), .o_ser_latch(latch));
	pfrc_core DUT (.i_mclk(mclk), .i_rst(rst), .i_ser_clk(sclk), .i_ser_data(sdata),
		.i_ser_latch(latch), .i_powered(powered), .i_rf_cmp(rfc), .i_if_cmp(ifc),
		.o_fl_out(fl_out), .o_fl_oe(fl_oe), .o_rf_ld_cmp(rf_ld), .o_if_ld_cmp(if_ld),
		.o_rf_sample(smp), .o_ctl(ctl), .o_pump_test(ptest));
	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Write a word and let decode settle
	task automatic put(input logic [23:0] w);
		u_host.send(w);
		repeat (8) @(posedge mclk);
		#2;
	endtask : put
	// Compare strobes four cycles apart, counting the strobes out
	task automatic pulse(input int n);
		for (int i = 0; i < 4 * n; i++)
		begin
			@(posedge mclk) #1;
			rfc = (i % 4 == 0);
			ifc = rfc;
			#1;
			n_smp += smp;
			n_ld += rf_ld;
			n_if += if_ld;
		end
	endtask : pulse
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// Hang guard
	initial
	begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial
	begin
		rst = 1'b1;
		powered = 1'b0;
		rfc = 1'b0;
		ifc = 1'b0;
		repeat (3) @(posedge mclk);
		#1 chk({fl_oe, ctl}, 16'h0000);
		rst = 1'b0;
		repeat (2) @(posedge mclk);
		#1 powered = 1'b1;
		// Code 3 first so that the final code 0 has to move the pin off a driven level
		for (int c = 3; c >= 0; c--)
		begin
			put({6'h00, 14'(c), 4'hd});
			chk(16'({ctl.fast_active, fl_oe, fl_out}), 16'(pin_exp[c]));
		end
		put({2'h2, 4'hf, 14'h0008, 4'hd});
		chk(16'({ctl.fast_active, fl_oe, fl_out, ctl.pump_mult, ctl.slip_div}), 16'h1e04);
		n_smp = 0;
		n_ld = 0;
		pulse(15);
		chk(16'(ctl.fast_active), 16'h0001);
		pulse(1);
		chk(16'(ctl.fast_active), 16'h0000);
		chk(16'(n_smp), 16'h0004);
		chk(16'(n_ld), 16'h0010);
		// Slip code 3: divide by 16, pin low, unit pump
		put({2'h3, 4'h0, 14'h0002, 4'hd});
		chk(16'({ctl.fast_active, fl_oe, fl_out, ctl.pump_mult, ctl.slip_div}), 16'h0830);
		n_smp = 0;
		pulse(16);
		chk(16'(n_smp), 16'h0001);
		// Slip code 1: divide by 2, pin high, pump 6X
		put({2'h1, 4'h5, 14'h0003, 4'hd});
		chk(16'({ctl.fast_active, fl_oe, fl_out, ctl.pump_mult, ctl.slip_div}), 16'h0cc2);
		put({14'h0000, 6'h06, 4'hf});
		chk(16'(ctl[14:11]), 16'h000f);
		put({14'h0000, 6'h18, 4'hf});
		chk(16'(ctl[14:11]), 16'h0003);
		put({14'h0000, 6'h21, 4'hf});
		chk(16'({ptest, ctl[14:11]}), 16'h0010);
		put({20'hfffff, 4'h3});
		chk(16'({ptest, ctl[14:11]}), 16'h0010);
		n_ld = 0;
		pulse(8);
		chk(16'(n_ld), 16'h0002);
		chk(16'(n_if), 16'h0028);
		tally_and_finish();
	end
endmodule : pll_fastlock_reset_control_tb
`default_nettype wire

// ===== hdl/pfrc_cfg.svh
`ifndef PFRC_CFG_SVH
`define PFRC_CFG_SVH
// Word framing
`define PFRC_WORD_W 24
`define PFRC_ADDR_W 4
`define PFRC_ADDR_TIMEOUT 4'hd
`define PFRC_ADDR_RESET 4'hf
// Timeout word fields
`define PFRC_TOC_LSB 4
`define PFRC_TOC_W 14
`define PFRC_CPF_LSB 18
`define PFRC_CPF_W 4
`define PFRC_CSR_LSB 22
`define PFRC_CSR_W 2
// Reset/float word fields
`define PFRC_BIT_QUARTER 4
`define PFRC_BIT_IF_RST 5
`define PFRC_BIT_RF_COUNTER_RESET 6
`define PFRC_BIT_RF_PUMP_FLOAT 7
`define PFRC_BIT_IF_TRI 8
`define PFRC_BIT_CPT 9
// Timeout codes
`define PFRC_TOC_HIZ 14'h0000
`define PFRC_TOC_MANUAL 14'h0001
`define PFRC_TOC_LOW 14'h0002
`define PFRC_TOC_HIGH 14'h0003
`define PFRC_TOC_MIN_EN 14'h0004
// Divider constants
`define PFRC_QDIV_LAST 2'h3
`define PFRC_CSR_CNT_W 4
`endif

// ===== hdl/pfrc_core.sv
// What this block does
// - Timeout codes 0, 2 and 3 turn fastlock off and make the pin a general output.
// - Timeout codes 4 and up turn fastlock on and make the pin the fastlock indicator.
// - Fastlock lasts twice the timeout value in comparison cycles, then ends.
// - With fastlock off the pin floats for code 0, drives low for 2, drives high for 3.
// - Code 1 is manual fastlock: pin low, all fastlock conditions forced on with no end.
// - The 4-bit pump code picks a fastlock pump strength of code plus one times.
// - The slip field disables reduction at 0 and divides the sample rate by 2, 4, 16.
// - The quarter-rate bit divides the RF lock-detect comparison strobe by 4, IF untouched.
// - IF counter reset holds the IF counters in reset and floats the IF pump; default 0.
// - RF counter reset holds the RF counters in reset and floats the RF pump; default 0.
// - Every power-up applies a counter reset automatically.
// - RF float bit floats the RF pump and leaves the RF counters running.
// - IF float bit floats the IF pump and leaves the IF counters running.
`include "pfrc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module pfrc_core
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Serial control pins
	input wire logic i_ser_clk,
	input wire logic i_ser_data,
	input wire logic i_ser_latch,
	// Power state
	input wire logic i_powered,
	// Comparison strobes
	input wire logic i_rf_cmp,
	input wire logic i_if_cmp,
	// Fastlock pin
	output logic o_fl_out,
	output logic o_fl_oe,
	// Lock detect strobes
	output logic o_rf_ld_cmp,
	output logic o_if_ld_cmp,
	// Slip-reduced sample strobe
	output logic o_rf_sample,
	// Analog controls
	output pfrc_pkg::pfrc_ctl_t o_ctl,
	output logic o_pump_test
);
	import pfrc_pkg::*;

	// ********************************
	// Pin synchronisers
	// ********************************
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sync3_r;
	logic pwr1_r;
	logic pwr2_r;
	logic pwr3_r;
	// Two flops before any logic; third flop only for edge detect
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sync3_r <= 3'h0;
			pwr1_r <= 1'b0;
			pwr2_r <= 1'b0;
			pwr3_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {i_ser_latch, i_ser_data, i_ser_clk};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			pwr1_r <= i_powered;
			pwr2_r <= pwr1_r;
			pwr3_r <= pwr2_r;
		end
	end

	logic sclk_rise;
	logic latch_rise;
	logic pwr_rise;
	assign sclk_rise = sync2_r[0] & ~sync3_r[0];
	assign latch_rise = sync2_r[2] & ~sync3_r[2];
	assign pwr_rise = pwr2_r & ~pwr3_r;

	// ********************************
	// Serial word and registers
	// ********************************
	logic [`PFRC_WORD_W-1:0] shift_r, shift_nxt;
	pfrc_tmo_t tmo_r, tmo_nxt;
	pfrc_rst_t rst_r, rst_nxt;
	logic load_r, load_nxt;
	logic pwr_rst_r, pwr_rst_nxt;

	// Shift MSB first; latch edge decodes address nibble
	always_comb
	begin
		shift_nxt = shift_r;
		tmo_nxt = tmo_r;
		rst_nxt = rst_r;
		load_nxt = 1'b0;
		pwr_rst_nxt = pwr_rise;
		if (sclk_rise)
			shift_nxt = {shift_r[`PFRC_WORD_W-2:0], sync2_r[1]};
		if (latch_rise)
		begin
			unique case (shift_r[`PFRC_ADDR_W-1:0])
				`PFRC_ADDR_TIMEOUT:
				begin
					tmo_nxt.timeout = shift_r[`PFRC_TOC_LSB +: `PFRC_TOC_W];
					tmo_nxt.pump_code = shift_r[`PFRC_CPF_LSB +: `PFRC_CPF_W];
					tmo_nxt.slip = shift_r[`PFRC_CSR_LSB +: `PFRC_CSR_W];
					load_nxt = 1'b1; // New word restarts a timed fastlock
				end
				`PFRC_ADDR_RESET:
				begin
					rst_nxt.quarter = shift_r[`PFRC_BIT_QUARTER];
					rst_nxt.if_reset = shift_r[`PFRC_BIT_IF_RST];
					rst_nxt.rf_reset = shift_r[`PFRC_BIT_RF_COUNTER_RESET];
					rst_nxt.rf_float = shift_r[`PFRC_BIT_RF_PUMP_FLOAT];
					rst_nxt.if_float = shift_r[`PFRC_BIT_IF_TRI];
					rst_nxt.pump_test = shift_r[`PFRC_BIT_CPT];
				end
				default:
				begin
					// Other registers belong to other blocks
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			shift_r <= '0;
			tmo_r <= '0;
			rst_r <= '0; // Reset and float bits default 0
			load_r <= 1'b0;
			pwr_rst_r <= 1'b0;
		end
		else
		begin
			shift_r <= shift_nxt;
			tmo_r <= tmo_nxt;
			rst_r <= rst_nxt;
			load_r <= load_nxt;
			pwr_rst_r <= pwr_rst_nxt;
		end
	end

	// ********************************
	// Fastlock timer
	// ********************************
	pfrc_state_t state_r, state_nxt;
	logic [`PFRC_TOC_W:0] cnt_r, cnt_nxt;
	logic timed_en;
	logic manual_en;
	assign timed_en = tmo_r.timeout >= `PFRC_TOC_MIN_EN;
	assign manual_en = tmo_r.timeout == `PFRC_TOC_MANUAL;

	// Counts comparison strobes; period is twice the programmed value
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			PFRC_IDLE:
			begin
				if (load_r && timed_en)
				begin
					state_nxt = PFRC_FAST;
					cnt_nxt = {tmo_r.timeout, 1'b0};
				end
			end
			PFRC_FAST:
			begin
				if (load_r)
					cnt_nxt = {tmo_r.timeout, 1'b0};
				else if (i_rf_cmp)
					cnt_nxt = cnt_r - 15'h0001;
				if (!timed_en)
					state_nxt = PFRC_IDLE;
				else if (!load_r && i_rf_cmp && cnt_r == 15'h0001)
					state_nxt = PFRC_DONE;
			end
			PFRC_DONE:
			begin
				if (load_r && timed_en)
				begin
					state_nxt = PFRC_FAST;
					cnt_nxt = {tmo_r.timeout, 1'b0};
				end
				else if (!timed_en)
					state_nxt = PFRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= PFRC_IDLE;
			cnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ********************************
	// Rate dividers
	// ********************************
	logic [1:0] qdiv_r, qdiv_nxt;
	logic [`PFRC_CSR_CNT_W-1:0] sdiv_r, sdiv_nxt;
	logic [`PFRC_CSR_CNT_W-1:0] sdiv_mask;
	logic ld_q_r, ld_q_nxt;
	logic smp_r, smp_nxt;

	// Mask picks the divide ratio: none, 2, 4, 16
	always_comb
	begin
		unique case (tmo_r.slip)
			2'h0: sdiv_mask = 4'h0;
			2'h1: sdiv_mask = 4'h1;
			2'h2: sdiv_mask = 4'h3;
			2'h3: sdiv_mask = 4'hf;
		endcase
	end

	always_comb
	begin
		qdiv_nxt = qdiv_r;
		sdiv_nxt = sdiv_r;
		ld_q_nxt = 1'b0;
		smp_nxt = 1'b0;
		if (i_rf_cmp)
		begin
			qdiv_nxt = qdiv_r + 2'h1;
			ld_q_nxt = (qdiv_r == `PFRC_QDIV_LAST);
			sdiv_nxt = (sdiv_r + 4'h1) & sdiv_mask;
			smp_nxt = (sdiv_r == sdiv_mask);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			qdiv_r <= 2'h0;
			sdiv_r <= '0;
			ld_q_r <= 1'b0;
			smp_r <= 1'b0;
		end
		else
		begin
			qdiv_r <= qdiv_nxt;
			sdiv_r <= sdiv_nxt;
			ld_q_r <= ld_q_nxt;
			smp_r <= smp_nxt;
		end
	end

	// Strobes are pulses; divided path only when bit set, IF always direct
	assign o_rf_ld_cmp = rst_r.quarter ? ld_q_r : i_rf_cmp;
	assign o_if_ld_cmp = i_if_cmp;
	// Sample strobe runs at all times; the analog side decides when to use it
	assign o_rf_sample = smp_r;

	// ********************************
	// Outputs
	// ********************************
	pfrc_ctl_t ctl_r, ctl_nxt;
	logic fl_out_r, fl_out_nxt;
	logic fl_oe_r, fl_oe_nxt;
	logic fast_on;
	// Gate with the enable so a low code ends fastlock with the pin enable in step
	assign fast_on = manual_en || (state_r == PFRC_FAST && timed_en);

	always_comb
	begin
		ctl_nxt.fast_active = fast_on;
		ctl_nxt.pump_mult = {1'b0, tmo_r.pump_code} + 5'h01;
		ctl_nxt.slip_div = 5'h01 + {1'b0, sdiv_mask};
		ctl_nxt.rf_cnt_reset = rst_r.rf_reset | pwr_rst_r;
		ctl_nxt.if_cnt_reset = rst_r.if_reset | pwr_rst_r;
		ctl_nxt.rf_pump_hiz = rst_r.rf_reset | rst_r.rf_float | pwr_rst_r;
		ctl_nxt.if_pump_hiz = rst_r.if_reset | rst_r.if_float | pwr_rst_r;
		fl_oe_nxt = 1'b1;
		fl_out_nxt = 1'b0;
		if (timed_en)
			fl_out_nxt = (state_r == PFRC_FAST);
		else
		begin
			unique case (tmo_r.timeout[1:0])
				2'h0: fl_oe_nxt = 1'b0;
				2'h1: fl_out_nxt = 1'b0;
				2'h2: fl_out_nxt = 1'b0;
				2'h3: fl_out_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctl_r <= '0;
			fl_out_r <= 1'b0;
			fl_oe_r <= 1'b0;
		end
		else
		begin
			ctl_r <= ctl_nxt;
			fl_out_r <= fl_out_nxt;
			fl_oe_r <= fl_oe_nxt;
		end
	end

	assign o_ctl = ctl_r;
	assign o_fl_out = fl_out_r;
	assign o_fl_oe = fl_oe_r;
	assign o_pump_test = rst_r.pump_test;
endmodule : pfrc_core
`default_nettype wire

// ===== hdl/pfrc_pkg.sv
package pfrc_pkg;
	// Decoded timeout word
	typedef struct packed {
		logic [1:0] slip;
		logic [3:0] pump_code;
		logic [13:0] timeout;
	} pfrc_tmo_t;
	// Decoded reset/float word
	typedef struct packed {
		logic pump_test;
		logic if_float;
		logic rf_float;
		logic rf_reset;
		logic if_reset;
		logic quarter;
	} pfrc_rst_t;
	// Analog-side control outputs
	typedef struct packed {
		logic rf_cnt_reset;
		logic if_cnt_reset;
		logic rf_pump_hiz;
		logic if_pump_hiz;
		logic fast_active;
		logic [4:0] pump_mult;
		logic [4:0] slip_div;
	} pfrc_ctl_t;
	typedef enum logic [2:0] {
		PFRC_IDLE = 3'b001,
		PFRC_FAST = 3'b010,
		PFRC_DONE = 3'b100
	} pfrc_state_t;
endpackage : pfrc_pkg
